// [adccfg_regs.svh]
// Purpose: Register offsets, field positions and reset values of the channel register set.
// Assumes: Avalon-MM byte addressing, one 16-bit register per aligned 32-bit word.
// Notes:   Byte address is four times the register index.
`ifndef ADCCFG_REGS_SVH
`define ADCCFG_REGS_SVH

// ****************************************************************
// Register indexes
// ****************************************************************
`define ADCCFG_IDX_CHANNEL_CONFIG  8'h1d
`define ADCCFG_IDX_OFFSET_CAL_HIGH 8'h1e
`define ADCCFG_IDX_OFFSET_CAL_LOW  8'h1f
`define ADCCFG_IDX_GAIN_CAL_HIGH   8'h20

// ****************************************************************
// Reset values
// ****************************************************************
`define ADCCFG_RST_CHANNEL_CONFIG  16'h0000
`define ADCCFG_RST_OFFSET_CAL_HIGH 16'h0000
`define ADCCFG_RST_OFFSET_CAL_LOW  16'h0000
`define ADCCFG_RST_GAIN_CAL_HIGH   16'h8000

// ****************************************************************
// Field layout
// ****************************************************************
`define ADCCFG_PHASE_MSB        15
`define ADCCFG_PHASE_LSB        6
`define ADCCFG_DCBLK_BIT        2
`define ADCCFG_MUX_MSB          1
`define ADCCFG_MUX_LSB          0
`define ADCCFG_CFG_WMASK        16'hffc7
`define ADCCFG_OCL_WMASK        16'hff00
`define ADCCFG_OCL_FIELD_MSB    15
`define ADCCFG_OCL_FIELD_LSB    8
`define ADCCFG_MUX_EXTERNAL     2'h0
`define ADCCFG_MUX_SHORTED      2'h1
`define ADCCFG_MUX_TEST_POS     2'h2
`define ADCCFG_MUX_TEST_NEG     2'h3
`define ADCCFG_ADDR_WORD_LSB    2
`define ADCCFG_UNMAPPED_RDATA   32'h0000_0000

`endif

// [adccfg_pkg.sv]
// Purpose: Types shared by the channel register set.
// Assumes: Nothing beyond the register header.
// Notes:   Types only; numbers live in the header.
package adccfg_pkg;

	typedef enum logic [1:0] {
		ADCCFG_SEL_EXTERNAL = 2'b00,
		ADCCFG_SEL_SHORTED  = 2'b01,
		ADCCFG_SEL_TEST_POS = 2'b10,
		ADCCFG_SEL_TEST_NEG = 2'b11
	} adccfg_sel_t;

	typedef enum logic [1:0] {
		ADCCFG_BUS_IDLE  = 2'b00,
		ADCCFG_BUS_REPLY = 2'b01
	} adccfg_bus_t;

endpackage : adccfg_pkg

// [adccfg_decode.sv]
// Purpose: Decode of the input select field into one-hot routing controls.
// Assumes: Same clock as the register set.
// Notes:   Registered outputs keep the analog switch controls glitch free.
`include "adccfg_regs.svh"

module adccfg_decode (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic [1:0] sel_i,
	output logic            route_external_o,
	output logic            route_shorted_o,
	output logic            route_test_pos_o,
	output logic            route_test_neg_o
);

	typedef struct packed {
		logic [3:0] onehot;
	} adccfg_dec_state_t;

	adccfg_dec_state_t st_reg;
	adccfg_dec_state_t st_next;

	function automatic logic [3:0] adccfg_onehot(input logic [1:0] s);
		logic [3:0] r;
		r = 4'h0;
		case (adccfg_pkg::adccfg_sel_t'(s))
			adccfg_pkg::ADCCFG_SEL_EXTERNAL: r = 4'h1;
			adccfg_pkg::ADCCFG_SEL_SHORTED:  r = 4'h2;
			adccfg_pkg::ADCCFG_SEL_TEST_POS: r = 4'h4;
			adccfg_pkg::ADCCFG_SEL_TEST_NEG: r = 4'h8;
			default:                         r = 4'h1;
		endcase
		return r;
	endfunction : adccfg_onehot

	always_comb begin
		st_next.onehot = adccfg_onehot(sel_i); // R03
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			st_reg.onehot <= 4'h1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign route_external_o = st_reg.onehot[0];
	assign route_shorted_o  = st_reg.onehot[1];
	assign route_test_pos_o = st_reg.onehot[2];
	assign route_test_neg_o = st_reg.onehot[3];

	chk_sel_onehot: assert property (@(posedge clk_i) disable iff (!rstn_i) // R03
		$past(rstn_i) |-> (st_reg.onehot == (4'h1 << $past(sel_i))))
		else $error("select decode wrong");

endmodule : adccfg_decode

// [adccfg_chan_regs.sv]
// Purpose: Configuration and calibration registers of one converter channel.
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, one fixed wait state.
// Notes:   Unmapped reads return zero and unmapped writes are dropped.
//
// Implementation choice: the Avalon-MM register port.
`include "adccfg_regs.svh"

// Operation
// [R01] Phase delay is a 10-bit signed count of modulator cycles in config bits 15:6.
// [R02] Config bit 2 set turns the DC block off for this channel, clear follows the global setting.
// [R03] Input select 00 routes the pin pair, 01 shorts inputs, 10 and 11 apply positive and negative test.
// [R04] Offset high register holds bits 23:8 of the signed 24-bit offset value.
// [R05] Offset low register holds bits 7:0 in its upper byte; its lower byte reads zero.
// [R06] Configuration sits at index 1Dh and resets to 0000h.
// [R07] Gain high word sits at index 20h and resets to 8000h, unity gain.
// [R08] Offset high and low sit at 1Eh and 1Fh and reset to zero.
// [R09] Configuration bits 5:3 always read zero.
// [R10] Gain value is an unsigned fraction from zero to just under two.
// [R11] Writes to reserved bits are ignored without disturbing the writable fields.
module adccfg_chan_regs (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        global_dc_block_setting_i,
	output logic      [9:0]  channel_phase_delay_o,
	output logic             channel_dc_block_off_o,
	output logic             dc_block_active_o,
	output logic      [1:0]  channel_input_select_o,
	output logic             route_external_o,
	output logic             route_shorted_o,
	output logic             route_test_pos_o,
	output logic             route_test_neg_o,
	output logic      [23:0] offset_cal_o,
	output logic      [23:0] gain_cal_high_field_o
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		adccfg_pkg::adccfg_bus_t bus;
		logic [31:0]             rdata;
		logic                    waitreq;
		logic [15:0]             channel_config;
		logic [15:0]             offset_cal_high;
		logic [15:0]             offset_cal_low;
		logic [15:0]             gain_cal_high;
		logic                    dc_active;
	} adccfg_state_t;

	adccfg_state_t st_reg;
	adccfg_state_t st_next;

	logic [5:0] word_idx;
	assign word_idx = avs_address_i[7:`ADCCFG_ADDR_WORD_LSB];

	// Byte-lane merge; only low two lanes carry register bits
	function automatic logic [15:0] adccfg_merge(input logic [15:0] old_v,
	                                             input logic [15:0] new_v,
	                                             input logic [1:0]  be,
	                                             input logic [15:0] wmask);
		logic [15:0] lane;
		lane = {{8{be[1]}}, {8{be[0]}}} & wmask;
		return (old_v & ~lane) | (new_v & lane);
	endfunction : adccfg_merge

	function automatic logic adccfg_hit(input logic [5:0] idx, input logic [7:0] reg_idx);
		return ({2'b00, idx} == reg_idx);
	endfunction : adccfg_hit

	// ****************************************************************
	// Bus slave and register update
	// ****************************************************************
	// Waitrequest high by default; one reply cycle drops it, so every
	// access completes at the second edge after it is presented.
	always_comb begin
		st_next           = st_reg;
		st_next.waitreq   = 1'b1;
		st_next.bus       = adccfg_pkg::ADCCFG_BUS_IDLE;
		st_next.dc_active = global_dc_block_setting_i & ~st_reg.channel_config[`ADCCFG_DCBLK_BIT]; // R02
		case (st_reg.bus)
			adccfg_pkg::ADCCFG_BUS_IDLE: begin
				if (avs_read_i || avs_write_i) begin
					st_next.bus    = adccfg_pkg::ADCCFG_BUS_REPLY;
					st_next.waitreq = 1'b0;
					st_next.rdata  = `ADCCFG_UNMAPPED_RDATA;
					if (avs_write_i) begin
						if (adccfg_hit(word_idx, `ADCCFG_IDX_CHANNEL_CONFIG)) begin
							st_next.channel_config = adccfg_merge(st_reg.channel_config,
								avs_writedata_i[15:0], avs_byteenable_i[1:0],
								`ADCCFG_CFG_WMASK); // R01 R02 R09 R11
						end
						if (adccfg_hit(word_idx, `ADCCFG_IDX_OFFSET_CAL_HIGH)) begin
							st_next.offset_cal_high = adccfg_merge(st_reg.offset_cal_high,
								avs_writedata_i[15:0], avs_byteenable_i[1:0],
								16'hffff); // R04
						end
						if (adccfg_hit(word_idx, `ADCCFG_IDX_OFFSET_CAL_LOW)) begin
							st_next.offset_cal_low = adccfg_merge(st_reg.offset_cal_low,
								avs_writedata_i[15:0], avs_byteenable_i[1:0],
								`ADCCFG_OCL_WMASK); // R05 R11
						end
						if (adccfg_hit(word_idx, `ADCCFG_IDX_GAIN_CAL_HIGH)) begin
							st_next.gain_cal_high = adccfg_merge(st_reg.gain_cal_high,
								avs_writedata_i[15:0], avs_byteenable_i[1:0],
								16'hffff); // R10
						end
					end else begin
						if (adccfg_hit(word_idx, `ADCCFG_IDX_CHANNEL_CONFIG)) begin
							st_next.rdata = {16'h0000,
								st_reg.channel_config & `ADCCFG_CFG_WMASK}; // R09
						end
						if (adccfg_hit(word_idx, `ADCCFG_IDX_OFFSET_CAL_HIGH)) begin
							st_next.rdata = {16'h0000, st_reg.offset_cal_high};
						end
						if (adccfg_hit(word_idx, `ADCCFG_IDX_OFFSET_CAL_LOW)) begin
							st_next.rdata = {16'h0000,
								st_reg.offset_cal_low & `ADCCFG_OCL_WMASK}; // R05
						end
						if (adccfg_hit(word_idx, `ADCCFG_IDX_GAIN_CAL_HIGH)) begin
							st_next.rdata = {16'h0000, st_reg.gain_cal_high};
						end
					end
				end
			end
			adccfg_pkg::ADCCFG_BUS_REPLY: begin
				// Master drops request at this edge; idle one cycle
				st_next.bus = adccfg_pkg::ADCCFG_BUS_IDLE;
			end
			default: begin
				st_next.bus = adccfg_pkg::ADCCFG_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			st_reg.bus             <= adccfg_pkg::ADCCFG_BUS_IDLE;
			st_reg.rdata           <= 32'h0000_0000;
			st_reg.waitreq         <= 1'b1;
			st_reg.channel_config  <= `ADCCFG_RST_CHANNEL_CONFIG;  // R06
			st_reg.offset_cal_high <= `ADCCFG_RST_OFFSET_CAL_HIGH; // R08
			st_reg.offset_cal_low  <= `ADCCFG_RST_OFFSET_CAL_LOW;  // R08
			st_reg.gain_cal_high   <= `ADCCFG_RST_GAIN_CAL_HIGH;   // R07
			st_reg.dc_active       <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign avs_readdata_o         = st_reg.rdata;
	assign avs_waitrequest_o      = st_reg.waitreq;
	assign channel_phase_delay_o  = st_reg.channel_config[`ADCCFG_PHASE_MSB:`ADCCFG_PHASE_LSB]; // R01
	assign channel_dc_block_off_o = st_reg.channel_config[`ADCCFG_DCBLK_BIT]; // R02
	assign dc_block_active_o      = st_reg.dc_active;
	assign channel_input_select_o = st_reg.channel_config[`ADCCFG_MUX_MSB:`ADCCFG_MUX_LSB];
	// Signed 24-bit offset: high word then upper byte of the low word
	assign offset_cal_o = {st_reg.offset_cal_high,
		st_reg.offset_cal_low[`ADCCFG_OCL_FIELD_MSB:`ADCCFG_OCL_FIELD_LSB]}; // R04 R05
	// Low byte of gain lives in a register outside this block
	assign gain_cal_high_field_o = {st_reg.gain_cal_high, 8'h00}; // R10

	adccfg_decode u_decode (
		.clk_i            (clk_i),
		.rstn_i           (rstn_i),
		.sel_i            (st_reg.channel_config[`ADCCFG_MUX_MSB:`ADCCFG_MUX_LSB]),
		.route_external_o (route_external_o),
		.route_shorted_o  (route_shorted_o),
		.route_test_pos_o (route_test_pos_o),
		.route_test_neg_o (route_test_neg_o)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	chk_cfg_reserved_zero: assert property (@(posedge clk_i) disable iff (!rstn_i) // R09
		(!avs_waitrequest_o && $past(avs_read_i)
		 && adccfg_hit($past(word_idx), `ADCCFG_IDX_CHANNEL_CONFIG))
		|-> (avs_readdata_o[5:3] == 3'b000)) else $error("reserved config bits read nonzero");

	chk_ocl_low_zero: assert property (@(posedge clk_i) disable iff (!rstn_i) // R05
		(!avs_waitrequest_o && $past(avs_read_i)
		 && adccfg_hit($past(word_idx), `ADCCFG_IDX_OFFSET_CAL_LOW))
		|-> (avs_readdata_o[7:0] == 8'h00)) else $error("offset low byte read nonzero");

	chk_cfg_write_phase: assert property (@(posedge clk_i) disable iff (!rstn_i) // R01
		(st_reg.bus == adccfg_pkg::ADCCFG_BUS_IDLE && avs_write_i
		 && adccfg_hit(word_idx, `ADCCFG_IDX_CHANNEL_CONFIG)
		 && avs_byteenable_i == 4'hf)
		|=> (channel_phase_delay_o == $past(avs_writedata_i[15:6]))) else $error("phase not stored");

	// Judged only after a clean cycle, so a released reset is not held to stale inputs
	chk_dc_block_gate: assert property (@(posedge clk_i) disable iff (!rstn_i) // R02
		$past(rstn_i) |-> (dc_block_active_o == ($past(global_dc_block_setting_i)
		 && !$past(channel_dc_block_off_o)))) else $error("dc block gating wrong");

	chk_offset_concat: assert property (@(posedge clk_i) disable iff (!rstn_i) // R04
		(st_reg.bus == adccfg_pkg::ADCCFG_BUS_IDLE && avs_write_i
		 && adccfg_hit(word_idx, `ADCCFG_IDX_OFFSET_CAL_HIGH)
		 && avs_byteenable_i[1:0] == 2'h3)
		|=> (offset_cal_o[23:8] == $past(avs_writedata_i[15:0]))) else $error("offset high wrong");

	chk_reset_values: assert property (@(posedge clk_i) // R06
		!rstn_i |=> (channel_phase_delay_o == 10'h000 && channel_input_select_o == 2'h0
		 && !channel_dc_block_off_o && offset_cal_o == 24'h000000)) else $error("reset value wrong");

	chk_gain_reset: assert property (@(posedge clk_i) // R07
		!rstn_i |=> (gain_cal_high_field_o == 24'h800000)) else $error("gain reset not unity");

	chk_offset_reset: assert property (@(posedge clk_i) // R08
		!rstn_i |=> (st_reg.offset_cal_high == 16'h0000 && st_reg.offset_cal_low == 16'h0000))
		else $error("offset reset nonzero");

	chk_bus_answer: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(st_reg.bus == adccfg_pkg::ADCCFG_BUS_IDLE && (avs_read_i || avs_write_i))
		|=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer timing wrong");

	chk_reserved_write: assert property (@(posedge clk_i) disable iff (!rstn_i) // R11
		(st_reg.bus == adccfg_pkg::ADCCFG_BUS_IDLE && avs_write_i
		 && adccfg_hit(word_idx, `ADCCFG_IDX_CHANNEL_CONFIG))
		|=> (st_reg.channel_config[5:3] == 3'b000)) else $error("reserved bits stored");

endmodule : adccfg_chan_regs

// [tb_top.sv]
// Purpose: Self-checking bench for the channel configuration and calibration registers.
// Assumes: Register offsets and one-wait-state Avalon-MM timing as handed over by the designer.
// Notes:   Expected values are literal figures, not taken from the design.
`include "adccfg_regs.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_i;
	logic        rstn_i;
	logic [7:0]  avs_address_i;
	logic        avs_read_i;
	logic        avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [3:0]  avs_byteenable_i;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        global_dc_block_setting_i;
	logic [9:0]  channel_phase_delay_o;
	logic        channel_dc_block_off_o;
	logic        dc_block_active_o;
	logic [1:0]  channel_input_select_o;
	logic        route_external_o;
	logic        route_shorted_o;
	logic        route_test_pos_o;
	logic        route_test_neg_o;
	logic [23:0] offset_cal_o;
	logic [23:0] gain_cal_high_field_o;
	int          fail_count;
	int          checks_done;
	int          cycle_count;
	logic [31:0] rd;

	adccfg_chan_regs adccfg_chan_regs_i (
		.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .global_dc_block_setting_i(global_dc_block_setting_i),
		.channel_phase_delay_o(channel_phase_delay_o), .channel_dc_block_off_o(channel_dc_block_off_o),
		.dc_block_active_o(dc_block_active_o), .channel_input_select_o(channel_input_select_o),
		.route_external_o(route_external_o), .route_shorted_o(route_shorted_o),
		.route_test_pos_o(route_test_pos_o), .route_test_neg_o(route_test_neg_o),
		.offset_cal_o(offset_cal_o), .gain_cal_high_field_o(gain_cal_high_field_o)
	);

	// ****************************************************************
	// Clock, timeout and reporting
	// ****************************************************************
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycle_count <= cycle_count + 1;
		// Whole run needs well under a thousand cycles
		if (cycle_count == 5000) begin
			fail_count++;
			test_done();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done

	// ****************************************************************
	// Bus master
	// ****************************************************************
	// Starts one edge after the last release so no signal is driven twice in a step
	task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [15:0] wd,
	                        input logic [3:0] be, output logic [31:0] data);
		int n;
		@(posedge clk_i);
		avs_address_i    <= a;
		avs_read_i       <= ~wr;
		avs_write_i      <= wr;
		avs_writedata_i  <= {16'h0000, wd};
		avs_byteenable_i <= be;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0);
		data = avs_readdata_o;
		// One wait state: answer seen at the second edge
		check("wait cycles", n, 32'h2);
		avs_read_i  <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus_xfer

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] wd, input logic [3:0] be);
		logic [31:0] dummy;
		bus_xfer(1'b1, a, wd, be, dummy);
	endtask : wr_reg

	task automatic rd_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] data;
		bus_xfer(1'b0, a, 16'h0000, 4'hf, data);
		check(what, data, exp);
	endtask : rd_reg

	// Route and filter outputs trail the register by one more edge
	task automatic settle();
		repeat (2) @(posedge clk_i);
		#1;
	endtask : settle

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic test_reset_values();
		rd_reg("config", 8'h74, 32'h0000_0000);
		rd_reg("offset high", 8'h78, 32'h0000_0000);
		rd_reg("offset low", 8'h7c, 32'h0000_0000);
		rd_reg("gain high", 8'h80, 32'h0000_8000);
		rd_reg("unmapped", 8'h84, 32'h0000_0000);
		settle();
		check("gain out", {8'h00, gain_cal_high_field_o}, 32'h0080_0000);
		check("route", {route_external_o, route_shorted_o, route_test_pos_o, route_test_neg_o}, 4'h8);
		check("dc active", {31'h0, dc_block_active_o}, {31'h0, global_dc_block_setting_i});
		$display("test reset values done");
	endtask : test_reset_values

	task automatic test_config();
		logic [15:0] cfg;
		wr_reg(8'h74, 16'hffff, 4'hf);
		rd_reg("config reserved", 8'h74, 32'h0000_ffc7);
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_i);
			global_dc_block_setting_i <= 1'b1;
			cfg = {10'h201, 3'b111, s[0], s[1:0]};
			wr_reg(8'h74, cfg, 4'hf);
			rd_reg("config", 8'h74, {16'h0000, cfg & 16'hffc7});
			settle();
			check("phase", channel_phase_delay_o, 10'h201);
			check("select", channel_input_select_o, s[1:0]);
			check("route", {route_external_o, route_shorted_o, route_test_pos_o, route_test_neg_o},
			      4'h8 >> s);
			check("dc off", channel_dc_block_off_o, s[0]);
			check("dc active", dc_block_active_o, {31'h0, ~s[0]});
		end
		$display("test config done");
	endtask : test_config

	task automatic test_offset();
		wr_reg(8'h78, 16'h8123, 4'hf);
		wr_reg(8'h7c, 16'h45ff, 4'hf);
		rd_reg("offset low", 8'h7c, 32'h0000_4500);
		settle();
		check("offset out", offset_cal_o, 24'h812345);
		wr_reg(8'h7c, 16'haaff, 4'h1);
		wr_reg(8'h78, 16'h77ff, 4'h2);
		rd_reg("offset low lane", 8'h7c, 32'h0000_4500);
		rd_reg("offset high lane", 8'h78, 32'h0000_7723);
		$display("test offset done");
	endtask : test_offset

	task automatic test_gain();
		wr_reg(8'h80, 16'hffff, 4'hf);
		rd_reg("gain max", 8'h80, 32'h0000_ffff);
		settle();
		check("gain out", gain_cal_high_field_o, 24'hffff00);
		wr_reg(8'h84, 16'h1234, 4'hf);
		rd_reg("unmapped", 8'h84, 32'h0000_0000);
		rd_reg("gain kept", 8'h80, 32'h0000_ffff);
		$display("test gain done");
	endtask : test_gain

	// Second reset in mid-run must restore every register
	task automatic test_rerun_reset();
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		test_reset_values();
		rd_reg("offset high", 8'h78, 32'h0000_0000);
		$display("test rerun reset done");
	endtask : test_rerun_reset

	initial begin
		fail_count                = 0;
		checks_done               = 0;
		cycle_count               = 0;
		rstn_i                    = 1'b0;
		avs_address_i             = 8'h00;
		avs_read_i                = 1'b0;
		avs_write_i               = 1'b0;
		avs_writedata_i           = 32'h0000_0000;
		avs_byteenable_i          = 4'h0;
		global_dc_block_setting_i = 1'b0;
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		test_reset_values();
		test_config();
		test_offset();
		test_gain();
		test_rerun_reset();
		test_done();
	end
endmodule : tb_top
